/* File: hdl/pmc_device.sv */
// Device end: serial management engine, sleep and interrupt pin, gpio
// Contract
// - Station keeps management clock at most 25 MHz
// - Management logic runs in its own domain
// - Only one side drives data line
// - Shared pin is sleep input after reset
// - Low shared pin puts device asleep
// - Register access keeps working while asleep
// - Interrupt pulls pin low, open-drain only
// - Station writes register to enable interrupt
// - Reset returns all registers to defaults
// - Reset held low at least 1 us
// - Reference clock is 25 MHz, 50 ppm
// - Each gpio picks function from select register
`timescale 1ns/100ps
module pmc_device #(
	parameter pmc_pkg::pmc_addr_t PHY_ADDR = pmc_pkg::PHY_ADDR_DEF
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link
	pmc_if.device link,
	// User side
	input wire pmc_pkg::pmc_cause_t cause_i,
	output pmc_pkg::pmc_cause_t pending_o,
	output logic sleep_o,
	output pmc_pkg::pmc_gpio_t gpio_o
);
	import pmc_pkg::*;

	// ------------------------------------------------------------
	// Link domain state
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		D_IDLE = 6'h01,
		D_HDR = 6'h02,
		D_RTA = 6'h04,
		D_RD = 6'h08,
		D_WTA = 6'h10,
		D_WD = 6'h20
	} pmc_dstate_t;

	typedef struct packed {
		pmc_dstate_t state;
		logic [5:0] ones;
		logic [4:0] cnt;
		pmc_word_t shreg;
		pmc_addr_t regad;
		logic mdio_o;
		logic mdio_oe;
		logic irq_mode;
		logic [3:0] mask;
		logic [3:0] pinsel;
		logic [3:0] clr_mask;
		logic clr_tgl;
	} pmc_link_st_t;

	// ------------------------------------------------------------
	// Core domain state
	// ------------------------------------------------------------
	typedef struct packed {
		pmc_cause_t pending;
		logic tgl_seen;
		logic mode;
		logic [3:0] mask;
		logic [3:0] pinsel;
		logic irq_oe;
		logic sleep;
		pmc_gpio_t gpio;
	} pmc_core_st_t;

	pmc_link_st_t m;
	pmc_link_st_t next_m;
	pmc_core_st_t c;
	pmc_core_st_t next_c;
	pmc_cause_t pending_l;
	logic [1:0] core_sync;
	logic pin_low_s;
	logic tgl_s;
	logic [12:0] hdr;
	pmc_word_t wdata;
	pmc_word_t rdata;
	pmc_cause_t clr;
	logic irq_act;

	// ------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------
	// pending into link
	pmc_sync #(.W(NCAUSE)) u_sync_link (
		.clk_i(link.mdc),
		.rst_n_i(rst_n_i),
		.d_i(c.pending),
		.q_o(pending_l)
	);

	// pin level and write toggle into core
	pmc_sync #(.W(2)) u_sync_core (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({~link.irq_or_sleep_pin, m.clr_tgl}),
		.q_o(core_sync)
	);

	assign pin_low_s = core_sync[1];
	assign tgl_s = core_sync[0];

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	always_comb begin
		rdata = 16'h0000;
		if (m.regad == REG_CTRL) begin
			rdata[CTRL_IRQ_MODE_BIT] = m.irq_mode;
		end else if (m.regad == REG_MASK) begin
			rdata[3:0] = m.mask;
		end else if (m.regad == REG_STATUS) begin
			rdata[3:0] = pending_l;
		end else if (m.regad == REG_PINSEL) begin
			rdata[3:0] = m.pinsel;
		end
	end

	// ------------------------------------------------------------
	// Serial engine on the management clock
	// ------------------------------------------------------------
	always_comb begin
		next_m = m;
		hdr = {m.shreg[11:0], link.mdio};
		wdata = {m.shreg[14:0], link.mdio};
		case (m.state)
			D_IDLE: begin
				if (link.mdio) begin
					if (m.ones != 6'(PREAMBLE_LEN)) begin
						next_m.ones = m.ones + 6'h01;
					end
				end else if (m.ones == 6'(PREAMBLE_LEN)) begin
					next_m.state = D_HDR;
					next_m.cnt = 5'h00;
					next_m.ones = 6'h00;
				end else begin
					next_m.ones = 6'h00;
				end
			end
			D_HDR: begin
				next_m.shreg = wdata;
				next_m.cnt = m.cnt + 5'h01;
				if (m.cnt == 5'(HDR_BITS - 1)) begin
					next_m.state = D_IDLE;
					next_m.regad = hdr[4:0];
					next_m.cnt = 5'h00;
					if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
						if (hdr[11:10] == OP_READ) begin
							next_m.state = D_RTA;
						end else if (hdr[11:10] == OP_WRITE) begin
							next_m.state = D_WTA;
						end
					end
				end
			end
			D_RTA: begin
				next_m.mdio_oe = 1'b1;
				next_m.mdio_o = 1'b0;
				next_m.shreg = rdata;
				next_m.state = D_RD;
				next_m.cnt = 5'h00;
			end
			D_RD: begin
				if (m.cnt == 5'(DATA_BITS)) begin
					next_m.mdio_oe = 1'b0;
					next_m.mdio_o = 1'b0;
					next_m.state = D_IDLE;
				end else begin
					next_m.mdio_o = m.shreg[15];
					next_m.shreg = {m.shreg[14:0], 1'b0};
					next_m.cnt = m.cnt + 5'h01;
				end
			end
			D_WTA: begin
				next_m.cnt = m.cnt + 5'h01;
				if (m.cnt == 5'h01) begin
					next_m.state = D_WD;
					next_m.cnt = 5'h00;
				end
			end
			D_WD: begin
				next_m.shreg = wdata;
				next_m.cnt = m.cnt + 5'h01;
				if (m.cnt == 5'(DATA_BITS - 1)) begin
					next_m.state = D_IDLE;
					next_m.clr_mask = 4'h0;
					next_m.clr_tgl = ~m.clr_tgl;
					if (m.regad == REG_CTRL) begin
						next_m.irq_mode = wdata[CTRL_IRQ_MODE_BIT];
					end else if (m.regad == REG_MASK) begin
						next_m.mask = wdata[3:0];
					end else if (m.regad == REG_STATUS) begin
						next_m.clr_mask = wdata[3:0];
					end else if (m.regad == REG_PINSEL) begin
						next_m.pinsel = wdata[3:0];
					end
				end
			end
			default: begin
				next_m.state = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge link.mdc or negedge rst_n_i) begin
		if (!rst_n_i) begin
			m <= '{state: D_IDLE, ones: 6'h00, cnt: 5'h00,
				shreg: 16'h0000, regad: 5'h00, mdio_o: 1'b0,
				mdio_oe: 1'b0, irq_mode: CTRL_IRQ_MODE_RST,
				mask: MASK_RST, pinsel: PINSEL_RST,
				clr_mask: 4'h0, clr_tgl: 1'b0};
		end else begin
			m <= next_m;
		end
	end

	// ------------------------------------------------------------
	// Core domain: pending, shared pin, gpio
	// ------------------------------------------------------------
	always_comb begin
		next_c = c;
		clr = 4'h0;
		if (tgl_s != c.tgl_seen) begin
			clr = m.clr_mask;
			next_c.mode = m.irq_mode;
			next_c.mask = m.mask;
			next_c.pinsel = m.pinsel;
		end
		next_c.tgl_seen = tgl_s;
		next_c.pending = (c.pending & ~clr) | cause_i;
		irq_act = c.mode && ((c.pending & c.mask) != 4'h0);
		next_c.irq_oe = irq_act;
		next_c.sleep = ~c.mode & pin_low_s;
		for (int i = 0; i < NGPIO; i++) begin
			case (c.pinsel[2*i +: 2])
				FN_LOW: next_c.gpio[i] = 1'b0;
				FN_HIGH: next_c.gpio[i] = 1'b1;
				FN_IRQ: next_c.gpio[i] = c.irq_oe;
				default: next_c.gpio[i] = c.sleep;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.mdio_dev_o = m.mdio_o;
	assign link.mdio_dev_oe = m.mdio_oe;
	assign link.irq_or_sleep_pin_dev_o = 1'b0;
	assign link.irq_or_sleep_pin_dev_oe = c.irq_oe;
	assign pending_o = c.pending;
	assign sleep_o = c.sleep;
	assign gpio_o = c.gpio;
endmodule

/* File: hdl/pmc_if.sv */
// Link wires between management station and device
`timescale 1ns/100ps
interface pmc_if;
	logic mdc;
	logic mdio_sta_o;
	logic mdio_sta_oe;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	logic mdio;
	logic irq_or_sleep_pin_sta_o;
	logic irq_or_sleep_pin_sta_oe;
	logic irq_or_sleep_pin_dev_o;
	logic irq_or_sleep_pin_dev_oe;
	logic irq_or_sleep_pin;
	logic phy_rst_n;

	// Pull-up resolution of the shared wires
	assign mdio = mdio_sta_oe ? mdio_sta_o :
		(mdio_dev_oe ? mdio_dev_o : 1'b1);
	assign irq_or_sleep_pin =
		~((irq_or_sleep_pin_sta_oe & ~irq_or_sleep_pin_sta_o) |
		(irq_or_sleep_pin_dev_oe & ~irq_or_sleep_pin_dev_o));

	modport device (
		input mdc,
		input mdio,
		input irq_or_sleep_pin,
		output mdio_dev_o,
		output mdio_dev_oe,
		output irq_or_sleep_pin_dev_o,
		output irq_or_sleep_pin_dev_oe
	);

	modport station (
		input mdio,
		input irq_or_sleep_pin,
		output mdc,
		output mdio_sta_o,
		output mdio_sta_oe,
		output irq_or_sleep_pin_sta_o,
		output irq_or_sleep_pin_sta_oe,
		output phy_rst_n
	);
endinterface

/* File: hdl/pmc_pkg.sv */
// Shared constants and types for the management and control pins
package pmc_pkg;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int PREAMBLE_LEN = 32;
	localparam int HDR_BITS = 13;
	localparam int DATA_BITS = 16;
	localparam int FRAME_BITS = 64;
	localparam int TA_BIT = 46;
	localparam int DATA_BIT = 48;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [31:0] PREAMBLE = 32'hffffffff;

	// ------------------------------------------------------------
	// Device register map
	// ------------------------------------------------------------
	localparam int NCAUSE = 4;
	localparam int NGPIO = 2;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_MASK = 5'h01;
	localparam logic [4:0] REG_STATUS = 5'h02;
	localparam logic [4:0] REG_PINSEL = 5'h03;
	localparam int CTRL_IRQ_MODE_BIT = 0;
	localparam logic CTRL_IRQ_MODE_RST = 1'b0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [3:0] PINSEL_RST = 4'h0;
	localparam logic [4:0] PHY_ADDR_DEF = 5'h01;

	// ------------------------------------------------------------
	// Pin function codes
	// ------------------------------------------------------------
	localparam logic [1:0] FN_LOW = 2'h0;
	localparam logic [1:0] FN_HIGH = 2'h1;
	localparam logic [1:0] FN_IRQ = 2'h2;
	localparam logic [1:0] FN_SLEEP = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESET_MIN_NS = 1000;
	localparam int RESET_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int MDC_MAX_KHZ = 25000;
	localparam int MDC_DIV_DEF = 4;

	typedef logic [4:0] pmc_addr_t;
	typedef logic [15:0] pmc_word_t;
	typedef logic [NCAUSE-1:0] pmc_cause_t;
	typedef logic [NGPIO-1:0] pmc_gpio_t;

endpackage

/* File: hdl/pmc_station.sv */
// Station end: frame master, clock divider, reset and sleep drive
`timescale 1ns/100ps
module pmc_station #(
	parameter int MDC_DIV = pmc_pkg::MDC_DIV_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link
	pmc_if.station link,
	// Request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire pmc_pkg::pmc_addr_t req_phy_i,
	input wire pmc_pkg::pmc_addr_t req_reg_i,
	input wire pmc_pkg::pmc_word_t req_wdata_i,
	// Answer
	output logic rsp_valid_o,
	output pmc_pkg::pmc_word_t rsp_rdata_o,
	// Pin control
	input wire logic reset_req_i,
	input wire logic sleep_req_i,
	output logic irq_o
);
	import pmc_pkg::*;

	typedef enum logic [2:0] {
		S_RST = 3'h1,
		S_IDLE = 3'h2,
		S_RUN = 3'h4
	} pmc_sstate_t;

	typedef struct packed {
		pmc_sstate_t state;
		logic [7:0] phase;
		logic [6:0] bitn;
		logic [63:0] frame;
		logic is_read;
		pmc_word_t rdata;
		logic rsp_valid;
		logic mdc;
		logic mdio_o;
		logic mdio_oe;
		logic rst_n;
		logic [7:0] rst_cnt;
		logic sleep_oe;
		logic irq;
	} pmc_sta_st_t;

	pmc_sta_st_t s;
	pmc_sta_st_t next_s;
	logic [1:0] pin_s;

	// ------------------------------------------------------------
	// Pin inputs
	// ------------------------------------------------------------
	pmc_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({link.mdio, ~link.irq_or_sleep_pin}),
		.q_o(pin_s)
	);

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rsp_valid = 1'b0;
		next_s.irq = pin_s[0];
		next_s.sleep_oe = sleep_req_i;
		req_ready_o = (s.state == S_IDLE) && !reset_req_i;
		case (s.state)
			S_RST: begin
				// hold reset at least 1 us
				next_s.rst_n = 1'b0;
				next_s.rst_cnt = s.rst_cnt + 8'h01;
				if (s.rst_cnt == 8'(RESET_CYC - 1)) begin
					next_s.rst_n = 1'b1;
					next_s.state = S_IDLE;
				end
			end
			S_IDLE: begin
				if (reset_req_i) begin
					next_s.state = S_RST;
					next_s.rst_cnt = 8'h00;
					next_s.rst_n = 1'b0;
				end else if (req_valid_i) begin
					next_s.state = S_RUN;
					next_s.is_read = !req_write_i;
					next_s.frame = {PREAMBLE, START_CODE,
						req_write_i ? OP_WRITE : OP_READ,
						req_phy_i, req_reg_i,
						req_write_i ? TA_WRITE : 2'h0,
						req_write_i ? req_wdata_i : 16'h0000};
					next_s.phase = 8'h00;
					next_s.bitn = 7'h00;
					next_s.mdc = 1'b1;
				end
			end
			S_RUN: begin
				if (s.phase == 8'(MDC_DIV - 1)) begin
					if (s.is_read && s.bitn >= 7'(DATA_BIT) &&
						s.bitn < 7'(FRAME_BITS)) begin
						next_s.rdata = {s.rdata[14:0], pin_s[1]};
					end
					if (s.bitn == 7'(FRAME_BITS)) begin
						next_s.state = S_IDLE;
						next_s.mdc = 1'b0;
						next_s.rsp_valid = 1'b1;
					end else begin
						next_s.phase = 8'h00;
						next_s.bitn = s.bitn + 7'h01;
						next_s.mdc = 1'b1;
					end
				end else begin
					next_s.phase = s.phase + 8'h01;
					if (s.phase == 8'(MDC_DIV / 2 - 1)) begin
						next_s.mdc = 1'b0;
						next_s.mdio_o = s.frame[63];
						next_s.frame = {s.frame[62:0], 1'b0};
						next_s.mdio_oe = (s.bitn < 7'(FRAME_BITS)) &&
							!(s.is_read && s.bitn >= 7'(TA_BIT));
					end
				end
			end
			default: begin
				next_s.state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '{state: S_RST, phase: 8'h00, bitn: 7'h00,
				frame: 64'h0, is_read: 1'b0, rdata: 16'h0000,
				rsp_valid: 1'b0, mdc: 1'b0, mdio_o: 1'b0,
				mdio_oe: 1'b0, rst_n: 1'b0, rst_cnt: 8'h00,
				sleep_oe: 1'b0, irq: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.mdc = s.mdc;
	assign link.mdio_sta_o = s.mdio_o;
	assign link.mdio_sta_oe = s.mdio_oe;
	assign link.irq_or_sleep_pin_sta_o = 1'b0;
	assign link.irq_or_sleep_pin_sta_oe = s.sleep_oe;
	assign link.phy_rst_n = s.rst_n;
	assign rsp_valid_o = s.rsp_valid;
	assign rsp_rdata_o = s.rdata;
	assign irq_o = s.irq;
endmodule

/* File: hdl/pmc_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps
module pmc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	import pmc_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pmc_sync_st_t;

	pmc_sync_st_t r;
	pmc_sync_st_t next_r;

	always_comb begin
		next_r.meta = d_i;
		next_r.stable = r.meta;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.stable;
endmodule

/* File: test/phy_management_and_control_pins_tb.sv */
// Self-checking bench joining station and device ends
`timescale 1ns/100ps
module phy_management_and_control_pins_tb;
	import pmc_pkg::*;
	logic clk_i = 1'b0;
	logic dclk = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	pmc_addr_t req_phy_i = 5'h00;
	pmc_addr_t req_reg_i = 5'h00;
	pmc_word_t req_wdata_i = 16'h0000;
	logic reset_req_i = 1'b0;
	logic sleep_req_i = 1'b0;
	pmc_cause_t cause_i = 4'h0;
	logic req_ready_o;
	logic rsp_valid_o;
	logic irq_o;
	logic sleep_o;
	logic dev_rst_n;
	pmc_word_t rsp_rdata_o;
	pmc_cause_t pending_o;
	pmc_gpio_t gpio_o;
	logic [16:0] cap = 17'h00000;
	int bad_count = 0;
	int n_checks = 0;
	pmc_if link ();
	assign dev_rst_n = rst_n_i & link.phy_rst_n;
	always #25 clk_i = ~clk_i;
	always #20 dclk = ~dclk;
	// Bits the device puts on the wire, oldest first
	always @(negedge link.mdc) begin
		if (link.mdio_dev_oe) begin
			cap <= {cap[15:0], link.mdio};
		end
	end
	// --------------------------------------------------------
	// Instances
	// --------------------------------------------------------
	pmc_station #(.MDC_DIV(MDC_DIV_DEF)) i_pmc_station (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .link(link), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_write_i(req_write_i),
		.req_phy_i(req_phy_i), .req_reg_i(req_reg_i),
		.req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
		.rsp_rdata_o(rsp_rdata_o), .reset_req_i(reset_req_i),
		.sleep_req_i(sleep_req_i), .irq_o(irq_o));
	pmc_device i_pmc_device (.clk_i(dclk), .rst_n_i(dev_rst_n), .link(link),
		.cause_i(cause_i), .pending_o(pending_o), .sleep_o(sleep_o),
		.gpio_o(gpio_o));
	pmc_properties #(.MDC_DIV(MDC_DIV_DEF)) i_pmc_properties (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .mdc(link.mdc), .mdio_sta_oe(link.mdio_sta_oe),
		.mdio_dev_o(link.mdio_dev_o), .mdio_dev_oe(link.mdio_dev_oe),
		.irq_or_sleep_pin_sta_o(link.irq_or_sleep_pin_sta_o),
		.irq_or_sleep_pin_sta_oe(link.irq_or_sleep_pin_sta_oe),
		.irq_or_sleep_pin_dev_o(link.irq_or_sleep_pin_dev_o),
		.irq_or_sleep_pin_dev_oe(link.irq_or_sleep_pin_dev_oe),
		.phy_rst_n(link.phy_rst_n));
	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic chk_word(input pmc_word_t got, input pmc_word_t exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input pmc_addr_t phy,
		input pmc_addr_t rg, input pmc_word_t wd);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_phy_i <= phy;
		req_reg_i <= rg;
		req_wdata_i <= wd;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 2000);
		req_valid_i <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (rsp_valid_o !== 1'b1 && n < 400);
		chk_flag(rsp_valid_o, 1'b1);
	endtask
	task automatic wr(input pmc_addr_t rg, input pmc_word_t d);
		xfer(1'b1, PHY_ADDR_DEF, rg, d);
	endtask
	task automatic rd(input pmc_addr_t rg, input pmc_word_t exp);
		xfer(1'b0, PHY_ADDR_DEF, rg, 16'h0000);
		chk_word(rsp_rdata_o, exp);
	endtask
	task automatic settle();
		repeat (8) @(negedge clk_i);
	endtask
	task automatic pulse(input pmc_cause_t c);
		@(posedge dclk) cause_i <= c;
		@(posedge dclk) cause_i <= 4'h0;
	endtask
	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	// defaults after reset
	task automatic t_defaults();
		rd(REG_CTRL, 16'h0000);
		rd(REG_PINSEL, 16'h0000);
		chk_word({12'h000, pending_o}, 16'h0000);
		chk_flag(sleep_o, 1'b0);
	endtask
	task automatic t_pinsel();
		for (int c = 0; c < 4; c++) begin
			wr(REG_PINSEL, {12'h000, FN_HIGH, 2'(c)});
			settle();
			chk_word({14'h0, gpio_o}, {14'h0, 1'b1, c == 1});
		end
		rd(REG_PINSEL, 16'h0007);
		chk_word(cap[15:0], 16'h0007);
		chk_flag(cap[16], 1'b0);
		rd(5'h1f, 16'h0000);
		xfer(1'b0, 5'h02, REG_PINSEL, 16'h0000);
		chk_word(rsp_rdata_o, 16'hffff);
	endtask
	task automatic t_sleep();
		@(posedge clk_i) sleep_req_i <= 1'b1;
		settle();
		chk_flag(sleep_o, 1'b1);
		chk_word({14'h0, gpio_o}, 16'h0003);
		wr(REG_MASK, 16'h0003);
		rd(REG_MASK, 16'h0003);
		@(posedge clk_i) sleep_req_i <= 1'b0;
		settle();
		chk_flag(sleep_o, 1'b0);
	endtask
	task automatic t_irq();
		wr(REG_MASK, 16'h0001);
		wr(REG_CTRL, 16'h0001);
		pulse(4'h2);
		settle();
		chk_word({12'h000, pending_o}, 16'h0002);
		chk_flag(link.irq_or_sleep_pin, 1'b1);
		pulse(4'h1);
		settle();
		chk_flag(irq_o, 1'b1);
		chk_flag(link.irq_or_sleep_pin, 1'b0);
		chk_flag(sleep_o, 1'b0);
		wr(REG_PINSEL, 16'h0002);
		settle();
		chk_word({14'h0, gpio_o}, 16'h0001);
		rd(REG_STATUS, 16'h0003);
		wr(REG_STATUS, 16'h0001);
		settle();
		chk_word({12'h000, pending_o}, 16'h0002);
		chk_flag(irq_o, 1'b0);
		chk_word({14'h0, gpio_o}, 16'h0000);
	endtask
	task automatic t_reinit();
		wr(REG_PINSEL, 16'h0005);
		@(posedge clk_i) reset_req_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		reset_req_i <= 1'b0;
		rd(REG_CTRL, 16'h0000);
		rd(REG_STATUS, 16'h0000);
		chk_word({14'h0, gpio_o}, 16'h0000);
		chk_flag(irq_o, 1'b0);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_defaults();
		t_pinsel();
		t_sleep();
		t_irq();
		t_reinit();
		give_verdict();
	end
	initial begin
		#2000000;
		bad_count++;
		give_verdict();
	end
endmodule

/* File: test/pmc_properties.sv */
// Link checker for the management and control pins
`timescale 1ns/100ps
module pmc_properties
	import pmc_pkg::*;
#(
	parameter int MDC_DIV = pmc_pkg::MDC_DIV_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link wires
	input wire logic mdc,
	input wire logic mdio_sta_oe,
	input wire logic mdio_dev_o,
	input wire logic mdio_dev_oe,
	input wire logic irq_or_sleep_pin_sta_o,
	input wire logic irq_or_sleep_pin_sta_oe,
	input wire logic irq_or_sleep_pin_dev_o,
	input wire logic irq_or_sleep_pin_dev_oe,
	input wire logic phy_rst_n
);
	int oe_cnt;
	int low_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// --------------------------------------------------------
	// Helper counters
	// --------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oe_cnt <= 0;
			low_cnt <= 0;
		end else begin
			oe_cnt <= mdio_dev_oe ? oe_cnt + 1 : 0;
			low_cnt <= phy_rst_n ? 0 : low_cnt + 1;
		end
	end
	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	sequence s_turn;
		($past(mdio_sta_oe, 2) == 1'b0 && !mdio_dev_o) ##1 mdio_dev_oe[*4];
	endsequence
	sequence s_mdc_high;
		mdc[*2];
	endsequence
	a_one_driver: assert property (!(mdio_sta_oe && mdio_dev_oe))
		else $error("both ends drive the data line");
	a_turn_zero: assert property ($rose(mdio_dev_oe) |-> s_turn)
		else $error("bad turnaround on the data line");
	a_drive_len: assert property ($fell(mdio_dev_oe) |->
		oe_cnt == 17 * MDC_DIV)
		else $error("device drive length wrong");
	a_irq_open_drain: assert property (irq_or_sleep_pin_dev_oe |->
		!irq_or_sleep_pin_dev_o)
		else $error("shared pin driven high by device");
	a_sleep_open_drain: assert property (irq_or_sleep_pin_sta_oe |->
		!irq_or_sleep_pin_sta_o)
		else $error("shared pin driven high by station");
	a_mdc_high_time: assert property ($rose(mdc) |-> s_mdc_high)
		else $error("clock high phase too short");
	a_mdc_low_time: assert property ($fell(mdc) |=> !mdc)
		else $error("clock low phase too short");
	a_reset_width: assert property ($rose(phy_rst_n) |->
		low_cnt >= RESET_CYC)
		else $error("device reset pulse too short");
	a_reset_quiet: assert property (!phy_rst_n |->
		!mdio_dev_oe && !irq_or_sleep_pin_dev_oe)
		else $error("device drives during reset");
endmodule
